/* errpin_pkg.sv */
// constants and register map for the error pin and status append block
//
// Contract
// - with sync select clear, pin function comes from error-pin function field
// - function field 10 makes the shared pin an open-drain error output
// - error output pulls low when any of three error flags is set
// - function field 01 makes the pin an active-low error input
// - error input inverted and ORed into the conversion-error flag
// - error input level readable through the error-input level bit
// - function field 00 disables both error input and error output
// - function field 11 makes the pin a general-purpose output
// - when appending is enabled every result carries the status byte
// - status byte low two bits hold channel, plus error flags
// - temperature sensor selectable through the input mux like a channel
// - checksum error flag clears when status is explicitly read
// - conversion error holds while over/undervoltage lasts, not cleared by data read
package errpin_pkg;

  // ----------------------------------------------------------------
  // register byte offsets (wishbone word aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG   = 8'h04;
  localparam logic [7:0] ADDR_DATA     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // status byte fields
  // ----------------------------------------------------------------
  localparam int ST_RDY      = 7;
  localparam int ST_CONV_ERR = 6;
  localparam int ST_CRC_ERR  = 5;
  localparam int ST_REG_ERR  = 4;
  localparam int ST_ERR_LVL  = 2;

  // ----------------------------------------------------------------
  // pin config register fields
  // ----------------------------------------------------------------
  localparam int CFG_GP_DATA = 0;
  localparam int CFG_FUNC_LO = 1;
  localparam int CFG_SYNC_EN = 3;
  localparam int CFG_APPEND  = 4;
  localparam int CFG_TEMP    = 5;
  localparam logic [5:0] CFG_RESET = 6'h08;

  // interrupt events: conversion error, crc error, reg error, result
  localparam int IRQ_W = 4;

  // ----------------------------------------------------------------
  // error pin functions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FUNC_OFF  = 2'b00,
    FUNC_IN   = 2'b01,
    FUNC_OUT  = 2'b10,
    FUNC_GPIO = 2'b11
  } pin_func_type;

  localparam logic [1:0] CH_TEMP = 2'h3;

endpackage : errpin_pkg

/* error_pin_and_status_append.sv */
// error pin control, status byte and status append for converter results
`timescale 1ns/1ps
`default_nettype none
module error_pin_and_status_append
  import errpin_pkg::*;
#(
  parameter int DATA_W = 24
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // converter core side
  input  wire logic              conv_valid_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  input  wire logic [1:0]        conv_chan_i,
  input  wire logic              conv_range_err_i,
  input  wire logic              crc_err_set_i,
  input  wire logic              reg_err_i,
  output logic                   temp_sel_o,
  // shared sync/error pin
  input  wire logic              err_pin_i,
  output logic                   err_pin_o,
  output logic                   err_pin_oe_n_o,
  output logic                   sync_en_o,
  // result stream
  output logic                   res_valid_o,
  output logic [DATA_W+7:0]      res_data_o,
  output logic                   res_has_status_o,
  // interrupt
  output logic                   irq_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [5:0]        pin_config_register;
  logic              crc_err;
  logic [1:0]        chan;
  logic              rdy_n;
  logic [DATA_W-1:0] data;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic req       = cyc_i & stb_i & ~ack_o;
  wire logic wr        = req & we_i & sel_i[0];
  wire logic rd        = req & ~we_i;
  wire logic hit_stat  = adr_i == ADDR_STATUS;
  wire logic hit_cfg   = adr_i == ADDR_CONFIG;
  wire logic hit_data  = adr_i == ADDR_DATA;
  wire logic hit_istat = adr_i == ADDR_IRQ_STAT;
  wire logic hit_imask = adr_i == ADDR_IRQ_MASK;

  wire logic sync_en = pin_config_register[CFG_SYNC_EN];
  wire pin_func_type func = pin_func_type'(
    pin_config_register[CFG_FUNC_LO+1:CFG_FUNC_LO]);
  wire logic err_in_mode = ~sync_en & (func == FUNC_IN);
  wire logic err_out_mode = ~sync_en & (func == FUNC_OUT);
  wire logic gpio_mode = ~sync_en & (func == FUNC_GPIO);

  // pin level only counts in input mode; otherwise it is ignored
  wire logic error_input_level = err_in_mode & err_pin_i;
  wire logic ext_err = err_in_mode & ~err_pin_i;
  // live flag, holds while the fault lasts; a data read cannot clear it
  wire logic conv_err = conv_range_err_i | ext_err;
  wire logic any_err = conv_err | crc_err | reg_err_i;

  wire logic [7:0] status_byte = {rdy_n, conv_err, crc_err, reg_err_i,
                                  1'b0, error_input_level, chan};

  wire logic [IRQ_W-1:0] irq_ev = {conv_valid_i, reg_err_i,
                                   crc_err_set_i, conv_err};

  // ----------------------------------------------------------------
  // read mux; unmapped addresses read zero and still ack
  // ----------------------------------------------------------------
  wire logic [31:0] rd_mux =
    hit_stat  ? {24'h000000, status_byte} :
    hit_cfg   ? {26'h0000000, pin_config_register} :
    hit_data  ? {{(32-DATA_W){1'b0}}, data} :
    hit_istat ? {{(32-IRQ_W){1'b0}}, irq_stat} :
    hit_imask ? {{(32-IRQ_W){1'b0}}, irq_mask} : 32'h00000000;

  // ----------------------------------------------------------------
  // bus slave, one wait-free cycle: ack the edge after the request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (rd) begin
        dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_config_register <= CFG_RESET;
      irq_mask            <= '0;
    end else if (wr && hit_cfg) begin
      pin_config_register <= dat_i[5:0];
    end else if (wr && hit_imask) begin
      irq_mask <= dat_i[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // a new crc error in the read cycle wins over the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_err <= 1'b0;
    end else if (crc_err_set_i) begin
      crc_err <= 1'b1;
    end else if (rd && hit_stat) begin
      crc_err <= 1'b0;
    end
  end

  // ready-low goes high again once the data register is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_n <= 1'b1;
      chan  <= 2'h0;
      data  <= '0;
    end else if (conv_valid_i) begin
      rdy_n <= 1'b0;
      chan  <= conv_chan_i;
      data  <= conv_data_i;
    end else if (rd && hit_data) begin
      rdy_n <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= irq_ev | (irq_stat &
                  ~((wr && hit_istat) ? dat_i[IRQ_W-1:0] : '0));
    end
  end

  // a set mask bit silences its event; the status bit still records it
  assign irq_o = |(irq_stat & ~irq_mask);

  // ----------------------------------------------------------------
  // result stream; status taken from the live flags at this result
  // ----------------------------------------------------------------
  wire logic append = pin_config_register[CFG_APPEND];
  wire logic [7:0] app_byte = {1'b0, conv_err, crc_err, reg_err_i,
                               1'b0, error_input_level, conv_chan_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_valid_o      <= 1'b0;
      res_data_o       <= '0;
      res_has_status_o <= 1'b0;
    end else begin
      res_valid_o <= conv_valid_i;
      if (conv_valid_i) begin
        res_has_status_o <= append;
        res_data_o <= append ? {conv_data_i, app_byte}
                             : {8'h00, conv_data_i};
      end
    end
  end

  // ----------------------------------------------------------------
  // pin driver; error output is open drain and only pulls low, gpio mode drives both levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_pin_o      <= 1'b1;
      err_pin_oe_n_o <= 1'b1;
    end else if (err_out_mode) begin
      err_pin_o      <= 1'b0;
      err_pin_oe_n_o <= ~any_err;
    end else if (gpio_mode) begin
      err_pin_o      <= pin_config_register[CFG_GP_DATA];
      err_pin_oe_n_o <= 1'b0;
    end else begin
      err_pin_o      <= 1'b1;
      err_pin_oe_n_o <= 1'b1;
    end
  end

  assign sync_en_o  = sync_en;
  assign temp_sel_o = pin_config_register[CFG_TEMP];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_err_out_low: assert property (
    err_out_mode && any_err |=> !err_pin_oe_n_o && !err_pin_o)
    else $error("error output not pulled low");
  a_err_out_idle: assert property (
    err_out_mode && !any_err |=> err_pin_oe_n_o)
    else $error("error output driven with no error");
  a_pin_off: assert property (
    !sync_en && func == FUNC_OFF |=> err_pin_oe_n_o)
    else $error("pin driven while disabled");
  a_gpio_drive: assert property (
    gpio_mode |=> !err_pin_oe_n_o
      && err_pin_o == $past(pin_config_register[CFG_GP_DATA]))
    else $error("general purpose output wrong");
  a_ext_err: assert property (
    err_in_mode && !err_pin_i |-> status_byte[ST_CONV_ERR])
    else $error("external error not in conversion flag");
  a_err_level: assert property (
    err_in_mode |-> status_byte[ST_ERR_LVL] == err_pin_i)
    else $error("error input level not visible");
  a_sync_mode: assert property (
    sync_en |=> err_pin_oe_n_o)
    else $error("pin driven in sync mode");
  a_crc_clear: assert property (
    rd && hit_stat && !crc_err_set_i |=> !crc_err)
    else $error("crc flag not cleared on status read");
  sequence s_fault_on_read;
    conv_range_err_i && rd && hit_data ##1 conv_range_err_i;
  endsequence
  a_conv_hold: assert property (
    s_fault_on_read |-> status_byte[ST_CONV_ERR])
    else $error("conversion error lost on data read");
  sequence s_conv_app;
    conv_valid_i && append;
  endsequence
  a_app_chan: assert property (
    s_conv_app |=> res_valid_o && res_has_status_o
      && res_data_o[1:0] == $past(conv_chan_i))
    else $error("appended status missing channel");
  a_app_flags: assert property (
    s_conv_app |=> res_data_o[ST_CONV_ERR] == $past(conv_err)
      && res_data_o[ST_CRC_ERR] == $past(crc_err)
      && res_data_o[ST_REG_ERR] == $past(reg_err_i))
    else $error("appended status flags wrong");
  a_no_append: assert property (
    conv_valid_i && !append |=> res_valid_o && !res_has_status_o
      && res_data_o[DATA_W+7:DATA_W] == 8'h00)
    else $error("status byte appended while disabled");
  a_res_idle: assert property (
    !conv_valid_i |=> !res_valid_o)
    else $error("result valid without a conversion");
  a_open_drain: assert property (
    err_out_mode |=> !err_pin_o)
    else $error("error output driven high");
  a_ext_clear: assert property (
    err_in_mode && err_pin_i && !conv_range_err_i |-> !conv_err)
    else $error("conversion flag set with no error");
  a_lvl_off: assert property (
    !err_in_mode |-> !status_byte[ST_ERR_LVL])
    else $error("error input level shown outside input mode");
  a_crc_set: assert property (
    crc_err_set_i |=> status_byte[ST_CRC_ERR])
    else $error("crc flag lost in its set cycle");

  // ----------------------------------------------------------------
  // bus, ready and interrupt checks
  // ----------------------------------------------------------------
  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_once;
    ack_o ##1 !ack_o;
  endsequence
  a_bus_ack: assert property (
    s_bus_req |=> s_ack_once)
    else $error("bus request not acknowledged for one cycle");
  a_cfg_write: assert property (
    wr && hit_cfg |=> pin_config_register == $past(dat_i[5:0]))
    else $error("pin config write lost");
  a_rdy_set: assert property (
    conv_valid_i |=> !status_byte[ST_RDY])
    else $error("ready flag not set by a new result");
  a_rdy_clear: assert property (
    rd && hit_data && !conv_valid_i |=> status_byte[ST_RDY])
    else $error("ready flag not cleared by a data read");
  a_irq_set: assert property (
    crc_err_set_i |=> |irq_stat)
    else $error("crc event lost in interrupt status");
  a_stat_w1c: assert property (
    wr && hit_istat && irq_ev == '0
      |=> (irq_stat & $past(dat_i[IRQ_W-1:0])) == '0)
    else $error("interrupt status not cleared by write");

endmodule : error_pin_and_status_append
`default_nettype wire

/* ext_err_line.sv */
// partner model: external error line with pull-up on the shared pin
`timescale 1ns/1ps
`default_nettype none
module ext_err_line (
  // pin side
  input  wire logic drv_i,
  input  wire logic oe_n_i,
  input  wire logic pull_low_i,
  output logic      level_o
);
  // wired-and with pull-up: a released pin floats high, never stale
  assign level_o = !((!oe_n_i && !drv_i) || pull_low_i);
endmodule : ext_err_line
`default_nettype wire

/* test_error_pin_and_status_append.sv */
// self-checking bench for the error pin and status append block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_error_pin_and_status_append;
  import errpin_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc_i = 0;
  logic        stb_i = 0;
  logic        we_i = 0;
  logic [7:0]  adr_i = 0;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        conv_valid_i = 0;
  logic [23:0] conv_data_i = 0;
  logic [1:0]  conv_chan_i = 0;
  logic        conv_range_err_i = 0;
  logic        crc_err_set_i = 0;
  logic        reg_err_i = 0;
  logic        pull_low = 0;
  wire logic   err_pin_i;
  logic        temp_sel_o, err_pin_o, err_pin_oe_n_o, sync_en_o;
  logic        res_valid_o, res_has_status_o, irq_o;
  logic [31:0] res_data_o;
  logic [31:0] q;
  int          cmp_count = 0;
  int          n_errors = 0;

  error_pin_and_status_append u_dut (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .cyc_i            (cyc_i),
    .stb_i            (stb_i),
    .we_i             (we_i),
    .adr_i            (adr_i),
    .sel_i            (sel_i),
    .dat_i            (dat_i),
    .dat_o            (dat_o),
    .ack_o            (ack_o),
    .conv_valid_i     (conv_valid_i),
    .conv_data_i      (conv_data_i),
    .conv_chan_i      (conv_chan_i),
    .conv_range_err_i (conv_range_err_i),
    .crc_err_set_i    (crc_err_set_i),
    .reg_err_i        (reg_err_i),
    .temp_sel_o       (temp_sel_o),
    .err_pin_i        (err_pin_i),
    .err_pin_o        (err_pin_o),
    .err_pin_oe_n_o   (err_pin_oe_n_o),
    .sync_en_o        (sync_en_o),
    .res_valid_o      (res_valid_o),
    .res_data_o       (res_data_o),
    .res_has_status_o (res_has_status_o),
    .irq_o            (irq_o)
  );
  ext_err_line u_ext (.drv_i(err_pin_o), .oe_n_i(err_pin_oe_n_o),
    .pull_low_i(pull_low), .level_o(err_pin_i));

  always #5 clk_i = ~clk_i;

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // bus and event helpers
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask : wb

  task automatic crc_pulse;
    @(posedge clk_i);
    crc_err_set_i <= 1;
    @(posedge clk_i);
    crc_err_set_i <= 0;
    repeat (2) @(posedge clk_i);
  endtask : crc_pulse

  task automatic conv(input logic [1:0] ch, input logic [23:0] d);
    @(posedge clk_i);
    conv_valid_i <= 1;
    conv_chan_i <= ch;
    conv_data_i <= d;
    @(posedge clk_i);
    conv_valid_i <= 0;
    @(posedge clk_i);
    `CHK(res_valid_o, 1'b1)
  endtask : conv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_out;
    wb(0, ADDR_CONFIG, 0);
    `CHK(q[5:0], CFG_RESET)
    wb(1, ADDR_CONFIG, 32'h04);
    repeat (2) @(posedge clk_i);
    `CHK({sync_en_o, err_pin_oe_n_o}, 2'b01)
    reg_err_i <= 1;
    repeat (2) @(posedge clk_i);
    `CHK({err_pin_oe_n_o, err_pin_o, err_pin_i}, 3'b000)
    wb(0, ADDR_STATUS, 0);
    `CHK(q[4], 1'b1)
    reg_err_i <= 0;
    conv_range_err_i <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(err_pin_oe_n_o, 1'b0)
    conv_range_err_i <= 0;
    crc_pulse();
    `CHK(err_pin_oe_n_o, 1'b0)
    wb(0, ADDR_STATUS, 0);
    `CHK(q[5], 1'b1)
    repeat (2) @(posedge clk_i);
    `CHK(err_pin_oe_n_o, 1'b1)
    $display("error output test done");
  endtask : t_out

  task automatic t_in_off;
    wb(1, ADDR_CONFIG, 32'h02);
    pull_low <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(err_pin_oe_n_o, 1'b1)
    wb(0, ADDR_STATUS, 0);
    `CHK({q[6], q[2]}, 2'b10)
    pull_low <= 0;
    repeat (2) @(posedge clk_i);
    wb(0, ADDR_STATUS, 0);
    `CHK({q[6], q[2]}, 2'b01)
    // sync is turned on again here, so error output must not take the pin
    wb(1, ADDR_CONFIG, 32'h0C);
    reg_err_i <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(err_pin_oe_n_o, 1'b1)
    wb(1, ADDR_CONFIG, 0);
    pull_low <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(err_pin_oe_n_o, 1'b1)
    reg_err_i <= 0;
    wb(0, ADDR_STATUS, 0);
    `CHK(q[6], 1'b0)
    pull_low <= 0;
    wb(1, ADDR_CONFIG, 32'h07);
    repeat (2) @(posedge clk_i);
    `CHK({err_pin_oe_n_o, err_pin_o}, 2'b01)
    wb(1, ADDR_CONFIG, 32'h06);
    repeat (2) @(posedge clk_i);
    `CHK({err_pin_oe_n_o, err_pin_o}, 2'b00)
    $display("input, off and gpio test done");
  endtask : t_in_off

  task automatic t_app;
    wb(1, ADDR_CONFIG, 32'h10);
    conv_range_err_i <= 1;
    conv(2'h1, 24'hA5C3E1);
    `CHK({res_has_status_o, res_data_o[31:8]}, 25'h1A5C3E1)
    `CHK({res_data_o[7:3], res_data_o[1:0]}, 7'h21)
    wb(0, ADDR_DATA, 0);
    wb(0, ADDR_STATUS, 0);
    `CHK(q[6], 1'b1)
    conv_range_err_i <= 0;
    wb(1, ADDR_CONFIG, 32'h20);
    conv(CH_TEMP, 24'h123456);
    `CHK(res_data_o, 32'h00123456)
    `CHK({res_has_status_o, temp_sel_o}, 2'b01)
    $display("append test done");
  endtask : t_app

  task automatic t_irq;
    wb(1, ADDR_IRQ_MASK, 0);
    wb(1, ADDR_IRQ_STAT, 32'hF);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    crc_pulse();
    `CHK(irq_o, 1'b1)
    wb(1, ADDR_IRQ_MASK, 32'h2);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(1, ADDR_IRQ_MASK, 0);
    wb(1, ADDR_IRQ_STAT, 32'h2);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(0, 8'h20, 0);
    `CHK(q, 32'h0)
    $display("interrupt test done");
  endtask : t_irq

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_out();
    t_in_off();
    t_app();
    t_irq();
    finish_test();
  end

  // generous bound: the whole sequence needs about 110 cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
endmodule : test_error_pin_and_status_append
`default_nettype wire
